/* emp_pkg.sv */
// Constants, field layouts and carrier types of the external memory port configuration block
package emp_pkg;
    localparam int EMP_DW = 24;
    localparam int EMP_EXT_AW = 18;
    localparam int EMP_CMP_W = 12;
    localparam int EMP_SWAP_W = 8;
    localparam int EMP_AREAS = 4;

    // ------------------------------------------------------------
    // Register indices on the core register port
    // ------------------------------------------------------------
    localparam logic [3:0] EMP_REG_PLL = 4'h0;
    localparam logic [3:0] EMP_REG_BCR = 4'h1;
    localparam logic [3:0] EMP_REG_AREA_ATTRIBUTE_0 = 4'h2;
    localparam logic [3:0] EMP_REG_AREA_ATTRIBUTE_3 = 4'h5;
    localparam logic [3:0] EMP_REG_OMR = 4'h6;
    localparam logic [3:0] EMP_REG_SR = 4'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PLL_MF_LSB = 0;
    localparam int PLL_DF_LSB = 12;
    localparam int PLL_XLOW_BIT = 15;
    localparam int PLL_XDIS_BIT = 16;
    localparam int PLL_STOP_BIT = 17;
    localparam int PLL_EN_BIT = 18;
    localparam int PLL_CKDIS_BIT = 19;
    localparam int PLL_PD_LSB = 20;
    localparam int BCR_WS1_LSB = 5;
    localparam int BCR_WS2_LSB = 10;
    localparam int BCR_WS3_LSB = 13;
    localparam int BCR_WSD_LSB = 16;
    localparam int BCR_STAT_BIT = 21;
    localparam int BCR_LOCK_BIT = 22;
    localparam int BCR_REQH_BIT = 23;
    localparam int AAR_POL_BIT = 2;
    localparam int AAR_PEN_BIT = 3;
    localparam int AAR_XEN_BIT = 4;
    localparam int AAR_YEN_BIT = 5;
    localparam int AAR_SWAP_BIT = 6;
    localparam int AAR_PACK_BIT = 7;
    localparam int AAR_NCMP_LSB = 8;
    localparam int AAR_CMPV_LSB = 12;
    localparam int OMR_EBD_BIT = 4;
    localparam int OMR_MSW_BIT = 7;
    localparam int OMR_TAS_BIT = 11;
    localparam int OMR_BRT_BIT = 12;
    localparam int OMR_APD_BIT = 14;
    localparam int SR_COMPAT_BIT = 13;
    localparam int SR_CACHE_BIT = 19;

    localparam logic [1:0] AAR_TYPE_SYNC = 2'h0;
    localparam logic [1:0] AAR_TYPE_ASYNC = 2'h1;
    localparam logic [1:0] AAR_TYPE_DRAM = 2'h2;
    localparam logic [3:0] AAR_NCMP_MAX = 4'hC;

    localparam logic [1:0] EMP_SPACE_P = 2'h0;
    localparam logic [1:0] EMP_SPACE_X = 2'h1;
    localparam logic [1:0] EMP_SPACE_Y = 2'h2;

    // ------------------------------------------------------------
    // Reset values and sequencing constants
    // ------------------------------------------------------------
    localparam logic [23:0] PLL_RST = 24'h000000;
    localparam logic [23:0] BCR_RST = 24'h1FFFFF;
    localparam logic [23:0] AAR_RST = 24'h000000;
    localparam logic [23:0] OMR_RST = 24'h000000;
    localparam logic [23:0] SR_RST = 24'h080000;
    localparam logic [23:0] EMP_BOOT_ADDR = 24'hC00000;
    localparam logic [3:0] EMP_BOOT_MODE = 4'h0;
    localparam logic [1:0] EMP_HOLD_CYC = 2'h2;
    localparam logic [1:0] EMP_STRAP_WAIT = 2'h2;

    typedef enum logic [3:0] {
        EMP_IDLE = 4'b0001,
        EMP_SETUP = 4'b0010,
        EMP_STROBE = 4'b0100,
        EMP_HOLD = 4'b1000
    } emp_state_type;

    typedef struct packed {
        logic [23:0] addr;
        logic [1:0] space;
        logic write;
        logic [23:0] wdata;
    } emp_acc_type;

    typedef struct packed {
        logic [4:0] prediv;
        logic [12:0] mult;
        logic [7:0] lpdiv;
        logic [12:0] freq_num;
        logic [11:0] freq_den;
        logic crystal_drive_out_low;
        logic crystal_drive_out_dis;
        logic stop_run;
        logic pll_en;
        logic clkout_dis;
    } emp_clk_cfg_type;

    typedef struct packed {
        logic [3:0] op_mode;
        logic ext_disable;
        logic mem_switch;
        logic ta_sync;
        logic fast_release;
        logic any_combo;
        logic lock_hold;
        logic req_hold;
        logic cache_en;
        logic compat16;
        logic [3:0] dma_pack;
    } emp_mode_type;
endpackage

/* emp_area_match.sv */
// Address and space comparator of one attribute area
`timescale 1ns/1ps
`default_nettype none
module emp_area_match
    import emp_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int CMP_W = 12
)
(
    input wire logic [23:0] aar,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [1:0] space,
    output logic hit
);
    initial
    begin
        if (CMP_W > ADDR_W || CMP_W != EMP_CMP_W)
            $error("emp_area_match: compare width unsupported");
    end

    logic [3:0] ncmp;
    logic [CMP_W-1:0] mask;
    logic space_ok;

    // Counts above twelve behave as a full compare
    assign ncmp = (aar[AAR_NCMP_LSB +: 4] > AAR_NCMP_MAX) ? AAR_NCMP_MAX : aar[AAR_NCMP_LSB +: 4];

    genvar i;
    generate
        for (i = 0; i < CMP_W; i++)
        begin : g_mask
            assign mask[i] = (5'(i) >= (5'(CMP_W) - {1'b0, ncmp}));
        end
    endgenerate

    always_comb
    begin
        unique case (space)
            EMP_SPACE_P: space_ok = aar[AAR_PEN_BIT];
            EMP_SPACE_X: space_ok = aar[AAR_XEN_BIT];
            EMP_SPACE_Y: space_ok = aar[AAR_YEN_BIT];
            default: space_ok = 1'b0;
        endcase
    end

    assign hit = space_ok && (((addr[ADDR_W-1 -: CMP_W] ^ aar[AAR_CMPV_LSB +: CMP_W]) & mask) == '0);
endmodule
`default_nettype wire

/* emp_port_ctrl.sv */
// External memory port configuration registers and asynchronous access sequencer
`timescale 1ns/1ps
`default_nettype none
module emp_port_ctrl
    import emp_pkg::*;
#(
    parameter int AREAS = 4
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    output logic [23:0] reg_rdata,
    input wire logic acc_req,
    input wire emp_acc_type acc_cmd,
    output logic acc_busy,
    output logic acc_done,
    output logic acc_err,
    output logic [23:0] acc_rdata,
    input wire logic [3:0] boot_mode_bits,
    output logic boot_fetch,
    output logic [23:0] boot_addr,
    output logic [17:0] ext_addr,
    output logic [3:0] area_select_pin,
    output logic rd_n,
    output logic wr_n,
    input wire logic [23:0] ext_data_in,
    output logic [23:0] ext_data_out,
    output logic ext_data_oe,
    output emp_clk_cfg_type clk_cfg,
    output emp_mode_type mode_cfg
);
    initial
    begin
        if (AREAS != EMP_AREAS)
            $error("emp_port_ctrl: exactly four attribute areas supported");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [23:0] pll_r, bcr_r, omr_r, sr_r;
    logic [23:0] aar_r [EMP_AREAS];
    logic area_attribute_0_init_r;
    emp_state_type state_r, state_nxt;
    emp_acc_type cur_r, src;
    logic [5:0] cnt_r, len_nxt, exp_len_r;
    logic [1:0] hcnt_r, strap_cnt_r;
    logic [3:0] mode_s1_r, mode_s2_r;
    logic [23:0] din_s1_r, din_s2_r;
    logic [3:0] hit, pin_nxt;
    logic [4:0] ws_sel;
    logic [1:0] type_sel;
    logic swap_sel, take, refuse;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pll_r <= PLL_RST;
            bcr_r <= BCR_RST;
            sr_r <= SR_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == EMP_REG_PLL)
                pll_r <= reg_wdata;
            if (reg_addr == EMP_REG_BCR)
                bcr_r <= reg_wdata;
            if (reg_addr == EMP_REG_SR)
                sr_r <= reg_wdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < EMP_AREAS; g++)
        begin : g_area
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                    aar_r[g] <= AAR_RST;
                else if (reg_wr && reg_addr == EMP_REG_AREA_ATTRIBUTE_0 + 4'(g))
                    aar_r[g] <= reg_wdata;
            end
            emp_area_match #(.ADDR_W(EMP_DW), .CMP_W(EMP_CMP_W)) u_match (
                .aar(aar_r[g]),
                .addr(src.addr),
                .space(src.space),
                .hit(hit[g])
            );
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            area_attribute_0_init_r <= 1'b0;
        else if (reg_wr && reg_addr == EMP_REG_AREA_ATTRIBUTE_0)
            area_attribute_0_init_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // Boot strap capture
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        mode_s1_r <= boot_mode_bits;
        mode_s2_r <= mode_s1_r;
        din_s1_r <= ext_data_in;
        din_s2_r <= din_s1_r;
    end

    // Strap is read after the synchroniser has refilled
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            strap_cnt_r <= EMP_STRAP_WAIT;
        else if (strap_cnt_r != 2'h0)
            strap_cnt_r <= strap_cnt_r - 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            omr_r <= OMR_RST;
        else if (strap_cnt_r == 2'h1)
            omr_r[3:0] <= mode_s2_r;
        else if (reg_wr && reg_addr == EMP_REG_OMR)
            omr_r <= reg_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            boot_fetch <= 1'b0;
            boot_addr <= 24'h000000;
        end
        else
        begin
            boot_fetch <= (strap_cnt_r == 2'h1) && (mode_s2_r == EMP_BOOT_MODE);
            boot_addr <= EMP_BOOT_ADDR;
        end
    end

    // ------------------------------------------------------------
    // Register readback
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata <= 24'h000000;
        else if (reg_rd)
        begin
            if (reg_addr == EMP_REG_PLL)
                reg_rdata <= pll_r;
            else if (reg_addr == EMP_REG_BCR)
                reg_rdata <= {bcr_r[23:22], state_r != EMP_IDLE, bcr_r[20:0]};
            else if (reg_addr >= EMP_REG_AREA_ATTRIBUTE_0 && reg_addr <= EMP_REG_AREA_ATTRIBUTE_3)
                reg_rdata <= aar_r[2'(reg_addr - EMP_REG_AREA_ATTRIBUTE_0)];
            else if (reg_addr == EMP_REG_OMR)
                reg_rdata <= omr_r;
            else if (reg_addr == EMP_REG_SR)
                reg_rdata <= sr_r;
            else
                reg_rdata <= 24'h000000;
        end
    end

    // ------------------------------------------------------------
    // Clock and mode configuration outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            clk_cfg <= '0;
        else
        begin
            clk_cfg.prediv <= {1'b0, pll_r[PLL_PD_LSB +: 4]} + 5'h01;
            clk_cfg.mult <= {1'b0, pll_r[PLL_MF_LSB +: 12]} + 13'h0001;
            clk_cfg.lpdiv <= 8'h01 << pll_r[PLL_DF_LSB +: 3];
            clk_cfg.freq_num <= {1'b0, pll_r[PLL_MF_LSB +: 12]} + 13'h0001;
            clk_cfg.freq_den <= 12'({7'h00, {1'b0, pll_r[PLL_PD_LSB +: 4]} + 5'h01} << pll_r[PLL_DF_LSB +: 3]);
            clk_cfg.crystal_drive_out_low <= pll_r[PLL_XLOW_BIT];
            clk_cfg.crystal_drive_out_dis <= pll_r[PLL_XDIS_BIT];
            clk_cfg.stop_run <= pll_r[PLL_STOP_BIT];
            clk_cfg.pll_en <= pll_r[PLL_EN_BIT];
            clk_cfg.clkout_dis <= pll_r[PLL_CKDIS_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            mode_cfg <= '0;
        else
        begin
            mode_cfg.op_mode <= omr_r[3:0];
            mode_cfg.ext_disable <= omr_r[OMR_EBD_BIT];
            mode_cfg.mem_switch <= omr_r[OMR_MSW_BIT];
            mode_cfg.ta_sync <= omr_r[OMR_TAS_BIT];
            mode_cfg.fast_release <= omr_r[OMR_BRT_BIT];
            mode_cfg.any_combo <= omr_r[OMR_APD_BIT];
            mode_cfg.lock_hold <= bcr_r[BCR_LOCK_BIT];
            mode_cfg.req_hold <= bcr_r[BCR_REQH_BIT];
            mode_cfg.cache_en <= sr_r[SR_CACHE_BIT];
            mode_cfg.compat16 <= sr_r[SR_COMPAT_BIT];
            for (int k = 0; k < EMP_AREAS; k++)
                mode_cfg.dma_pack[k] <= aar_r[k][AAR_PACK_BIT];
        end
    end

    // ------------------------------------------------------------
    // Area selection and wait length
    // ------------------------------------------------------------
    // Hits look at the incoming command while idle so pins land with the address
    assign src = (state_r == EMP_IDLE) ? acc_cmd : cur_r;

    always_comb
    begin
        logic seen;
        seen = 1'b0;
        ws_sel = bcr_r[BCR_WSD_LSB +: 5];
        type_sel = AAR_TYPE_ASYNC;
        swap_sel = 1'b0;
        if (hit[0])
        begin
            ws_sel = bcr_r[4:0];
            type_sel = aar_r[0][1:0];
            swap_sel = aar_r[0][AAR_SWAP_BIT];
        end
        else if (hit[1])
        begin
            ws_sel = bcr_r[BCR_WS1_LSB +: 5];
            type_sel = aar_r[1][1:0];
            swap_sel = aar_r[1][AAR_SWAP_BIT];
        end
        else if (hit[2])
        begin
            ws_sel = {2'b00, bcr_r[BCR_WS2_LSB +: 3]};
            type_sel = aar_r[2][1:0];
            swap_sel = aar_r[2][AAR_SWAP_BIT];
        end
        else if (hit[3])
        begin
            ws_sel = {2'b00, bcr_r[BCR_WS3_LSB +: 3]};
            type_sel = aar_r[3][1:0];
            swap_sel = aar_r[3][AAR_SWAP_BIT];
        end
        // One strobe cycle plus waits plus the address-stability penalty
        len_nxt = 6'h01 + {1'b0, ws_sel} + {5'h00, type_sel == AAR_TYPE_ASYNC};
        pin_nxt = 4'h0;
        for (int k = 0; k < EMP_AREAS; k++)
        begin
            logic sel;
            sel = hit[k] && (omr_r[OMR_APD_BIT] || !seen) && (state_nxt != EMP_IDLE);
            seen = seen | hit[k];
            pin_nxt[k] = sel ? aar_r[k][AAR_POL_BIT] : !aar_r[k][AAR_POL_BIT];
        end
        if (!area_attribute_0_init_r)
            pin_nxt[0] = 1'b1;
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    assign take = acc_req && (state_r == EMP_IDLE);
    assign refuse = take && omr_r[OMR_EBD_BIT];

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            EMP_IDLE: if (take && !refuse) state_nxt = EMP_SETUP;
            EMP_SETUP: state_nxt = EMP_STROBE;
            EMP_STROBE: if (cnt_r == 6'h00) state_nxt = EMP_HOLD;
            EMP_HOLD: if (hcnt_r == 2'h0) state_nxt = EMP_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r <= EMP_IDLE;
            cur_r <= '0;
            cnt_r <= 6'h00;
            exp_len_r <= 6'h00;
            hcnt_r <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            if (take)
                cur_r <= acc_cmd;
            if (state_r == EMP_SETUP)
            begin
                cnt_r <= len_nxt - 6'h01;
                exp_len_r <= len_nxt;
            end
            else if (state_r == EMP_STROBE && cnt_r != 6'h00)
                cnt_r <= cnt_r - 6'h01;
            if (state_r == EMP_STROBE)
                hcnt_r <= EMP_HOLD_CYC - 2'h1;
            else if (hcnt_r != 2'h0)
                hcnt_r <= hcnt_r - 2'h1;
        end
    end

    // Address lines keep their last value between accesses
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ext_addr <= 18'h00000;
            area_select_pin <= 4'hF;
            ext_data_out <= 24'h000000;
        end
        else
        begin
            if (take && !refuse)
                ext_addr <= swap_sel ? {src.addr[EMP_SWAP_W-1:0], src.addr[EMP_EXT_AW-1:EMP_SWAP_W]}
                                     : src.addr[EMP_EXT_AW-1:0];
            area_select_pin <= pin_nxt;
            if (state_r == EMP_SETUP && cur_r.write)
                ext_data_out <= cur_r.wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            ext_data_oe <= 1'b0;
        end
        else
        begin
            rd_n <= !(state_nxt == EMP_STROBE && !cur_r.write);
            wr_n <= !(state_nxt == EMP_STROBE && cur_r.write);
            // Data stays driven through hold, after the write strobe is released
            ext_data_oe <= cur_r.write && (state_nxt == EMP_STROBE || state_nxt == EMP_HOLD);
        end
    end

    // Synchronised data reflects the pins at the strobe release edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            acc_rdata <= 24'h000000;
            acc_done <= 1'b0;
            acc_err <= 1'b0;
            acc_busy <= 1'b0;
        end
        else
        begin
            if (state_r == EMP_HOLD && hcnt_r == 2'h0 && !cur_r.write)
                acc_rdata <= din_s2_r;
            acc_done <= refuse || (state_r == EMP_HOLD && hcnt_r == 2'h0);
            acc_err <= refuse;
            acc_busy <= state_nxt != EMP_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [5:0] low_cnt;
    always_ff @(posedge clk)
    begin
        if (sys_rst || (rd_n && wr_n))
            low_cnt <= 6'h00;
        else
            low_cnt <= low_cnt + 6'h01;
    end

    strobe_length_a: assert property ($rose(rd_n & wr_n) |-> low_cnt == exp_len_r)
        else $error("strobe length differs from wait setting");
    async_penalty_a: assert property ((state_r == EMP_STROBE) && type_sel == AAR_TYPE_ASYNC |-> exp_len_r >= 6'h02)
        else $error("address-stable access without extra wait");
    read_order_a: assert property ($fell(rd_n) |-> $past(state_r) == EMP_SETUP && $stable(ext_addr))
        else $error("read strobe without address setup");
    write_data_a: assert property (!wr_n |-> ext_data_oe && ext_data_out == cur_r.wdata)
        else $error("write strobe without data");
    data_hold_a: assert property ($rose(wr_n) |-> ext_data_oe ##1 ext_data_oe)
        else $error("write data not held after strobe");
    aa0_reset_a: assert property ($past(!area_attribute_0_init_r) |-> area_select_pin[0])
        else $error("area pin 0 inactive before init");
    addr_trunc_a: assert property (state_r == EMP_STROBE && !swap_sel |-> ext_addr == cur_r.addr[17:0])
        else $error("external address not truncated address");
    boot_vec_a: assert property (boot_fetch |-> boot_addr == EMP_BOOT_ADDR && omr_r[3:0] == EMP_BOOT_MODE)
        else $error("boot fetch with wrong address or mode");
    prediv_out_a: assert property (1'b1 |=> clk_cfg.prediv == {1'b0, $past(pll_r[PLL_PD_LSB +: 4])} + 5'h01)
        else $error("predivider factor wrong");
    bus_off_a: assert property (take && omr_r[OMR_EBD_BIT] |=> acc_done && acc_err && rd_n && wr_n)
        else $error("disabled bus access not refused");

    read_seen_c: cover property ($rose(rd_n) ##[1:4] acc_done);
    write_seen_c: cover property ($rose(wr_n) ##[1:4] acc_done);
    refuse_seen_c: cover property (acc_done && acc_err);
    boot_seen_c: cover property (boot_fetch);
endmodule
`default_nettype wire

/* emp_mem_model.sv */
// Behavioural asynchronous memory on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module emp_mem_model
(
    input wire logic [17:0] ext_addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [23:0] ext_data_out,
    output logic [23:0] ext_data_in
);
    logic [23:0] mem [0:255];
    logic [23:0] last_r = 24'h000000;
    // Store on strobe release while data is still held
    always @(posedge wr_n)
        mem[ext_addr[7:0]] <= ext_data_out;
    always @(negedge rd_n)
        last_r <= mem[ext_addr[7:0]];
    // Released bus shows the inverse, never a stale copy
    assign ext_data_in = rd_n ? ~last_r : last_r;
endmodule
`default_nettype wire

/* emp_port_ctrl_tb.sv */
// Self-checking bench for the external memory port configuration block
`timescale 1ns/1ps
`default_nettype none
module emp_port_ctrl_tb;
    import emp_pkg::*;
    logic clk, sys_rst, reg_wr, reg_rd, acc_req, acc_busy, acc_done, acc_err, boot_fetch, rd_n, wr_n, ext_data_oe;
    logic [3:0] reg_addr, boot_mode_bits, area_select_pin;
    logic [23:0] reg_wdata, reg_rdata, acc_rdata, boot_addr, ext_data_in, ext_data_out;
    logic [17:0] ext_addr;
    emp_acc_type acc_cmd;
    emp_clk_cfg_type clk_cfg;
    emp_mode_type mode_cfg;
    int bad_count = 0;
    int total_checks = 0;
    int n;
    emp_port_ctrl emp_port_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_cmd(acc_cmd),
        .acc_busy(acc_busy), .acc_done(acc_done), .acc_err(acc_err), .acc_rdata(acc_rdata),
        .boot_mode_bits(boot_mode_bits), .boot_fetch(boot_fetch), .boot_addr(boot_addr), .ext_addr(ext_addr),
        .area_select_pin(area_select_pin), .rd_n(rd_n), .wr_n(wr_n), .ext_data_in(ext_data_in),
        .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .clk_cfg(clk_cfg), .mode_cfg(mode_cfg));
    emp_mem_model emp_mem_model_inst (.ext_addr(ext_addr), .rd_n(rd_n), .wr_n(wr_n),
        .ext_data_out(ext_data_out), .ext_data_in(ext_data_in));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_check(input logic [3:0] a, input logic [23:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1 check(reg_rdata, exp);
    endtask
    // Latency in edges after the take edge; pin is area pin 0 during the access
    task automatic access(input logic [23:0] a, input logic w, input logic [23:0] d, input int lat,
        input logic err, input logic pin);
        @(posedge clk);
        acc_req <= 1'b1;
        acc_cmd <= '{addr: a, space: EMP_SPACE_P, write: w, wdata: d};
        @(posedge clk);
        acc_req <= 1'b0;
        // A refusal answers on the take edge itself
        #1 n = 0;
        while (acc_done !== 1'b1)
        begin
            @(posedge clk);
            #1 n++;
            if (n == 1 && lat > 1)
            begin
                check({6'h00, ext_addr}, {6'h00, a[17:0]});
                check({23'h0, area_select_pin[0]}, {23'h0, pin});
                check({23'h0, acc_busy}, 24'h000001);
            end
            if (n == 2 && lat > 1)
                check(24'({ext_data_oe, wr_n, rd_n}), 24'({w, !w, w}));
            if (n == 2 && lat > 1 && w)
                check(ext_data_out, d);
            if (n == lat - 1 && lat > 1)
                check(24'({ext_data_oe, wr_n, rd_n}), 24'({w, 2'b11}));
            if (n > 100)
            begin
                bad_count++;
                stop_test;
            end
        end
        check(24'(n), 24'(lat));
        check({23'h0, acc_err}, {23'h0, err});
        check({23'h0, acc_busy}, 24'h000000);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        acc_req = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 24'h000000;
        acc_cmd = '0;
        boot_mode_bits = 4'h0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        // Strap lands two edges after release; the fetch pulse lasts one cycle
        repeat (2) @(posedge clk);
        #1 check({23'h0, boot_fetch}, 24'h000001);
        @(posedge clk);
        #1 check({23'h0, boot_fetch}, 24'h000000);
        check(24'({rd_n, wr_n, ext_data_oe, acc_busy}), 24'h00000C);
        check(boot_addr, EMP_BOOT_ADDR);
        check({23'h0, area_select_pin[0]}, 24'h000001);
        reg_check(EMP_REG_BCR, BCR_RST);
        reg_check(EMP_REG_SR, SR_RST);
        reg_check(4'hF, 24'h000000);
        reg_write(EMP_REG_PLL, 24'hF7F013);
        repeat (2) @(posedge clk);
        #1 check({19'h0, clk_cfg.prediv}, 24'h000010);
        check({11'h0, clk_cfg.mult}, 24'h000014);
        check({16'h0, clk_cfg.lpdiv}, 24'h000080);
        check({19'h0, clk_cfg.crystal_drive_out_low, clk_cfg.crystal_drive_out_dis, clk_cfg.stop_run, clk_cfg.pll_en, clk_cfg.clkout_dis},
            24'h00001E);
        check({12'h0, clk_cfg.freq_den}, 24'h000800);
        check({11'h0, clk_cfg.freq_num}, 24'h000014);
        reg_write(EMP_REG_AREA_ATTRIBUTE_0, 24'hC4063D);
        reg_write(EMP_REG_BCR, 24'h230008);
        reg_write(EMP_REG_OMR, 24'h004000);
        reg_check(EMP_REG_BCR, 24'h030008);
        check(24'({mode_cfg.any_combo, mode_cfg.cache_en, mode_cfg.compat16}), 24'h000006);
        // Area 0: eight waits plus the async one
        access(24'hC40010, 1'b1, 24'h5A5A5A, 13, 1'b0, 1'b1);
        access(24'hC40010, 1'b0, 24'h000000, 13, 1'b0, 1'b1);
        check(acc_rdata, 24'h5A5A5A);
        // No area hit: default count, same location by aliasing
        access(24'h000010, 1'b0, 24'h000000, 8, 1'b0, 1'b0);
        check(acc_rdata, 24'h5A5A5A);
        reg_write(EMP_REG_OMR, 24'h004010);
        access(24'hC40010, 1'b0, 24'h000000, 0, 1'b1, 1'b0);
        check({23'h0, mode_cfg.ext_disable}, 24'h000001);
        stop_test;
    end
endmodule
`default_nettype wire
